/* core/adc_seq_pkg.sv */
// shared constants, types and timing tables for the converter sequencer
package adc_seq_pkg;

  // ****************************************************************
  // clocks and timing
  // ****************************************************************
  localparam int CLK_KHZ        = 100000;  // hclk rate
  localparam int OSC_KHZ        = 4096;    // oscillator_frequency
  localparam int POR_OSC_CYCLES = 65536;   // two to the 16
  localparam int RST_HOLD_US    = 600;     // hold after pin reset, 0.6 ms
  localparam int RST_HOLD_OSC   = (RST_HOLD_US * OSC_KHZ + 999) / 1000;
  localparam int FRST_MOD       = 32;      // filter reset, modulator clocks
  localparam int CAL_OSC_EXTRA  = 50;
  localparam int CAL_CONVS      = 16;
  localparam int RATES          = 10;

  // conversion_latency after a start edge and in steady state, osc cycles
  localparam int FIRST_LAT [RATES] = '{820265, 412201, 208169, 103106,
    52098, 26594, 13314, 6946, 4674, 2370};
  localparam int NEXT_LAT [RATES] = '{816128, 408064, 204032, 102016,
    51008, 25504, 12736, 6368, 4096, 2048};

  // ****************************************************************
  // serial commands
  // ****************************************************************
  localparam logic [7:0] CMD_WAKEUP = 8'h00;
  localparam logic [7:0] CMD_SLEEP  = 8'h02;
  localparam logic [7:0] CMD_SYNC   = 8'h04;
  localparam logic [7:0] CMD_RDATA  = 8'h12;
  localparam logic [7:0] CMD_CAL    = 8'h62;
  localparam logic [3:0] CMD_WREG   = 4'h4;

  // ****************************************************************
  // serial config registers
  // ****************************************************************
  localparam logic [3:0] IDX_INPUT_MUX  = 4'h0;
  localparam logic [3:0] IDX_BIAS       = 4'h1;
  localparam logic [3:0] IDX_SECOND_MUX = 4'h2;
  localparam logic [3:0] IDX_RATE_GAIN  = 4'h3;
  localparam logic [7:0] RST_INPUT_MUX  = 8'h01;
  localparam logic [7:0] RST_BIAS       = 8'h00;
  localparam logic [7:0] RST_SECOND_MUX = 8'h00;
  localparam logic [7:0] RST_RATE_GAIN  = 8'h00;
  localparam int         RATE_LSB       = 0;
  localparam int         REFCON_LSB     = 5;

  // ****************************************************************
  // bus map
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CFG    = 8'h08;
  localparam logic [7:0] OFS_CMD    = 8'h0c;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'h0,
    ST_FRST  = 3'h1,
    ST_CONV  = 3'h3,
    ST_CAL   = 3'h2,
    ST_PDOWN = 3'h6
  } state_t;

  typedef struct packed {
    logic [7:0] rate_gain;
    logic [7:0] second_mux;
    logic [7:0] bias;
    logic [7:0] input_mux;
  } cfg_t;

endpackage

/* core/adc_seq.sv */
// conversion, sleep and reset sequencer with bus slave and serial port
// ****************************************************************
// Overview of operation
// R1: after power-up digital logic stays in reset for 65536 oscillator clocks
// R2: host keeps the serial port quiet until the power-on hold ends
// R3: sleep entered only by the sleep command or start pin low
// R4: reference stays on in sleep per the reference control field
// R5: calibration time follows the selected data rate
// R6: start high pulse launches one conversion; ready pin low marks done
// R7: pulsed mode powers down after a conversion, result still readable
// R8: host raises start before touching config registers during shutdown
// R9: stay down until start rises; then filter reset for 32 mod clocks
// R10: start to ready latency follows the data rate table
// R11: start held high converts continuously until start falls
// R12: reset pin low resets at once and holds while low
// R13: after reset pin release, hold 0.6 ms; host waits as well
// R14: pin reset returns clock selection to internal oscillator
// R15: each written config byte takes effect at its own byte end
// R16: host updates rate/gain before input mux when changing both
// R17: host leaves overload before changing the data rate
// R18: host sclk period at most 520 ns, byte starts within 4.2 us
// R19: host spaces separate writes to first four registers by 64 osc
// R20: host rewrites only input mux when cycling channels
// R21: config writes, sync command and start rise reset the filter
// R22: sleep request during calibration waits for calibration end
// R23: start rise or wakeup command leaves sleep with filter settling
// ****************************************************************
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
module adc_seq #(
  parameter int POR_CYCLES = adc_seq_pkg::POR_OSC_CYCLES,
  parameter int TIME_SHIFT = 0,
  parameter int MOD_DIV    = 16
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic               start_pin,
  input  wire logic               reset_pin_n,
  input  wire logic               sclk,
  input  wire logic               cs_n,
  input  wire logic               din,
  output logic                    data_out_ready_pin,
  output logic                    filter_reset,
  output logic                    powered_down,
  output logic                    reference_on,
  output logic                    digital_reset,
  output logic                    clk_sel_ext,
  output adc_seq_pkg::cfg_t       cfg
);
  import adc_seq_pkg::*;

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic [23:0] scale(input int n);
    scale = 24'((n >> TIME_SHIFT) < 1 ? 1 : (n >> TIME_SHIFT));
  endfunction

  function automatic logic [3:0] rate_idx(input logic [7:0] rg);
    logic [3:0] r;
    r = rg[RATE_LSB +: 4];
    rate_idx = (r > 4'h9) ? 4'h9 : r;
  endfunction

  function automatic logic is_cmd(input logic v, input logic [7:0] b,
                                  input logic [7:0] code);
    is_cmd = v && (b == code);
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [1:0] start_q, rstp_q, sclk_q, cs_q, din_q;
  logic       start_d, sclk_d;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_q <= 2'h0;
      rstp_q  <= 2'h3;
      sclk_q  <= 2'h0;
      cs_q    <= 2'h3;
      din_q   <= 2'h0;
      start_d <= 1'b0;
      sclk_d  <= 1'b0;
    end else begin
      start_q <= {start_q[0], start_pin};
      rstp_q  <= {rstp_q[0], reset_pin_n};
      sclk_q  <= {sclk_q[0], sclk};
      cs_q    <= {cs_q[0], cs_n};
      din_q   <= {din_q[0], din};
      start_d <= start_q[1];
      sclk_d  <= sclk_q[1];
    end
  end

  logic start_s, start_rise, pin_rst, sclk_rise;
  assign start_s    = start_q[1];
  assign start_rise = start_q[1] & ~start_d;
  assign pin_rst    = ~rstp_q[1];
  assign sclk_rise  = sclk_q[1] & ~sclk_d & ~cs_q[1];

  // ****************************************************************
  // oscillator tick, exact ratio by phase accumulator
  // ****************************************************************
  localparam logic [17:0] ACC_INC = 18'(OSC_KHZ);
  localparam logic [17:0] ACC_MOD = 18'(CLK_KHZ);
  logic [17:0] acc_r;
  logic [17:0] acc_sum;
  logic        osc_tick;
  assign acc_sum  = acc_r + ACC_INC;
  assign osc_tick = (acc_sum >= ACC_MOD);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) acc_r <= 18'h0;
    else acc_r <= osc_tick ? acc_sum - ACC_MOD : acc_sum;
  end

  // ****************************************************************
  // serial command receiver
  // ****************************************************************
  state_t      state_r;
  logic [2:0]  bit_r;
  logic [7:0]  shf_r;
  logic [1:0]  phase_r;
  logic [3:0]  waddr_r;
  logic [7:0]  wleft_r;
  logic        byte_v;
  logic [7:0]  byte_b;

  assign byte_v = sclk_rise && (bit_r == 3'h7) && (state_r != ST_HOLD);
  assign byte_b = {shf_r[6:0], din_q[1]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_r <= 3'h0;
      shf_r <= 8'h0;
    end else if (cs_q[1] || state_r == ST_HOLD) begin
      bit_r <= 3'h0;
    end else if (sclk_rise) begin
      bit_r <= bit_r + 3'h1;
      shf_r <= byte_b;
    end
  end

  logic ser_op, ser_wr;
  assign ser_op = byte_v && (phase_r == 2'h0);
  assign ser_wr = byte_v && (phase_r == 2'h2);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r <= 2'h0;
      waddr_r <= 4'h0;
      wleft_r <= 8'h0;
    end else if (cs_q[1] || state_r == ST_HOLD) begin
      phase_r <= 2'h0;
    end else if (byte_v) begin
      case (phase_r)
        2'h0: begin
          if (byte_b[7:4] == CMD_WREG) begin
            waddr_r <= byte_b[3:0];
            phase_r <= 2'h1;
          end
        end
        2'h1: begin
          wleft_r <= byte_b;
          phase_r <= 2'h2;
        end
        2'h2: begin
          waddr_r <= waddr_r + 4'h1;
          wleft_r <= wleft_r - 8'h1;
          if (wleft_r == 8'h0) phase_r <= 2'h0;
        end
        default: phase_r <= 2'h0;
      endcase
    end
  end

  // ****************************************************************
  // bus slave, zero wait states
  // ****************************************************************
  logic        ctrl_r;
  logic        wr_pend_r;
  logic [7:0]  waddr_bus_r;
  logic [31:0] rdata_r;
  logic        ready_n_r;
  logic        ahb_cmd;
  logic        addr_ok;
  logic [31:0] status_w;

  assign addr_ok   = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;
  assign ahb_cmd   = wr_pend_r && (waddr_bus_r == OFS_CMD);
  assign status_w  = {24'h0, 1'b0, ready_n_r, powered_down,
                      digital_reset, 1'b0, state_r};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r   <= 1'b0;
      waddr_bus_r <= 8'h0;
      rdata_r     <= 32'h0;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok) waddr_bus_r <= haddr[7:0];
      if (addr_ok && !hwrite) begin
        case (haddr[7:0])
          OFS_CTRL:   rdata_r <= {31'h0, ctrl_r};
          OFS_STATUS: rdata_r <= status_w;
          OFS_CFG:    rdata_r <= cfg;
          default:    rdata_r <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ctrl_r <= 1'b0;
    else if (pin_rst) ctrl_r <= 1'b0; // R14
    else if (wr_pend_r && waddr_bus_r == OFS_CTRL) ctrl_r <= hwdata[0];
  end
  assign clk_sel_ext = ctrl_r;

  // ****************************************************************
  // command events from either port; config writes from the serial port only
  // ****************************************************************
  logic ev_sleep, ev_wake, ev_sync, ev_cal, ev_rdata, ev_cfgwr;
  assign ev_sleep = is_cmd(ser_op, byte_b, CMD_SLEEP) ||
                    is_cmd(ahb_cmd, hwdata[7:0], CMD_SLEEP);
  assign ev_wake  = is_cmd(ser_op, byte_b, CMD_WAKEUP) ||
                    is_cmd(ahb_cmd, hwdata[7:0], CMD_WAKEUP);
  assign ev_sync  = is_cmd(ser_op, byte_b, CMD_SYNC) ||
                    is_cmd(ahb_cmd, hwdata[7:0], CMD_SYNC);
  assign ev_cal   = is_cmd(ser_op, byte_b, CMD_CAL) ||
                    is_cmd(ahb_cmd, hwdata[7:0], CMD_CAL);
  assign ev_rdata = is_cmd(ser_op, byte_b, CMD_RDATA) ||
                    is_cmd(ahb_cmd, hwdata[7:0], CMD_RDATA);
  assign ev_cfgwr = ser_wr && (waddr_r <= IDX_RATE_GAIN);

  // ****************************************************************
  // config registers
  // ****************************************************************
  // applied byte by byte, so a half-finished burst is already live
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= '{RST_RATE_GAIN, RST_SECOND_MUX, RST_BIAS, RST_INPUT_MUX};
    end else if (pin_rst || state_r == ST_HOLD) begin // R12 R13
      cfg <= '{RST_RATE_GAIN, RST_SECOND_MUX, RST_BIAS, RST_INPUT_MUX};
    end else if (ser_wr) begin // R15
      case (waddr_r)
        IDX_INPUT_MUX:  cfg.input_mux  <= byte_b;
        IDX_BIAS:       cfg.bias       <= byte_b;
        IDX_SECOND_MUX: cfg.second_mux <= byte_b;
        IDX_RATE_GAIN:  cfg.rate_gain  <= byte_b;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  localparam int FRST_OSC = FRST_MOD * MOD_DIV;
  logic [23:0] cnt_r;
  logic        first_r;
  logic        sleep_pend_r;
  logic [3:0]  rate;
  logic        cnt_done;
  logic        frst_ev;
  assign rate     = rate_idx(cfg.rate_gain);
  assign cnt_done = osc_tick && (cnt_r <= 24'h1);
  assign frst_ev  = start_rise || ev_sync || ev_cfgwr; // R21

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r      <= ST_HOLD;
      cnt_r        <= 24'h0;
      first_r      <= 1'b0;
      sleep_pend_r <= 1'b0;
    end else if (first_r == 1'b0 && state_r == ST_HOLD &&
                 cnt_r == 24'h0) begin
      cnt_r   <= scale(POR_CYCLES); // R1
      first_r <= 1'b1;
    end else if (pin_rst) begin // R12
      state_r      <= ST_HOLD;
      cnt_r        <= scale(RST_HOLD_OSC); // R13
      sleep_pend_r <= 1'b0;
    end else begin
      if (osc_tick && cnt_r != 24'h0) cnt_r <= cnt_r - 24'h1;
      case (state_r)
        ST_HOLD: begin
          if (cnt_done) begin
            state_r <= ST_FRST;
            cnt_r   <= scale(FRST_OSC);
          end
        end
        ST_FRST, ST_CONV: begin
          if (ev_cal) begin
            state_r      <= ST_CAL;
            sleep_pend_r <= 1'b0;
            cnt_r <= scale(CAL_OSC_EXTRA + FRST_OSC +
                           CAL_CONVS * NEXT_LAT[rate]); // R5
          end else if (ev_sleep) begin
            state_r <= ST_PDOWN; // R3
          end else if (frst_ev) begin
            state_r <= ST_FRST;
            cnt_r   <= scale(FRST_OSC);
          end else if (cnt_done && state_r == ST_FRST) begin
            state_r <= ST_CONV;
            cnt_r   <= scale(FIRST_LAT[rate] - FRST_OSC); // R10
          end else if (cnt_done) begin
            if (start_s) cnt_r <= scale(NEXT_LAT[rate]); // R11
            else state_r <= ST_PDOWN; // R7 R3
          end
        end
        ST_CAL: begin
          if (ev_sleep || !start_s) sleep_pend_r <= 1'b1; // R22
          if (cnt_done) begin
            if (sleep_pend_r || ev_sleep || !start_s) begin
              state_r <= ST_PDOWN; // R22
            end else begin
              state_r <= ST_CONV;
              cnt_r   <= scale(NEXT_LAT[rate]);
            end
          end
        end
        ST_PDOWN: begin
          if (start_rise || ev_wake) begin // R9 R23
            state_r <= ST_FRST;
            cnt_r   <= scale(FRST_OSC);
          end
        end
        default: state_r <= ST_HOLD;
      endcase
    end
  end

  // ****************************************************************
  // ready pin
  // ****************************************************************
  // done wins over a same-cycle read so no completion is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_n_r <= 1'b1;
    end else if (pin_rst || state_r == ST_HOLD || state_r == ST_FRST) begin
      ready_n_r <= 1'b1;
    end else if (cnt_done && (state_r == ST_CAL ||
                              (state_r == ST_CONV && !frst_ev))) begin
      ready_n_r <= 1'b0; // R6
    end else if (ev_rdata) begin
      ready_n_r <= 1'b1;
    end
  end
  assign data_out_ready_pin = ready_n_r;

  // ****************************************************************
  // reset, power and reference outputs
  // ****************************************************************
  assign filter_reset  = (state_r == ST_FRST) || (state_r == ST_HOLD);
  assign digital_reset = (state_r == ST_HOLD);
  assign powered_down  = (state_r == ST_PDOWN);
  assign reference_on  = !powered_down ||
                         (cfg.second_mux[REFCON_LSB +: 2] != 2'h0); // R4

endmodule

/* tb/adc_seq_monitor.sv */
// assertion checker watching the sequencer ports
`timescale 1ns/1ps
module adc_seq_monitor
  import adc_seq_pkg::*;
#(
  parameter int TIME_SHIFT = 0,
  parameter int MOD_DIV    = 16
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        start_pin,
  input wire logic        reset_pin_n,
  input wire logic        data_out_ready_pin,
  input wire logic        filter_reset,
  input wire logic        powered_down,
  input wire logic        reference_on,
  input wire logic        digital_reset,
  input wire logic        clk_sel_ext,
  input adc_seq_pkg::cfg_t cfg
);
  // ********
  // filter hold length, lower bound only: retriggers stretch it
  // ********
  localparam int FR_RAW = (32 * MOD_DIV) >> TIME_SHIFT;
  localparam int FR_T   = (FR_RAW > 0) ? FR_RAW : 1;
  localparam int FR_MIN = (FR_T - 1) * 24;
  logic [15:0] fr_cnt_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fr_cnt_r <= '0;
    end else if (!filter_reset || digital_reset) begin
      fr_cnt_r <= '0;
    end else if (fr_cnt_r != 16'hffff) begin
      fr_cnt_r <= fr_cnt_r + 16'h1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  unmapped_read_a: assert property (hsel && htrans[1] && !hwrite &&
    haddr[7:0] == 8'h10 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  ctrl_write_a: assert property (hsel && htrans[1] && hwrite &&
    haddr[7:0] == OFS_CTRL && reset_pin_n ##1 reset_pin_n
    |=> clk_sel_ext == $past(hwdata[0]))
    else $error("clock select write lost");
  pin_hold_a: assert property (!reset_pin_n [*4] |-> digital_reset)
    else $error("reset pin low without reset");
  pin_defaults_a: assert property (
    !reset_pin_n [*5] |-> cfg == 32'h0000_0001 && !clk_sel_ext)
    else $error("defaults not restored by reset pin");
  ref_sleep_a: assert property (
    (powered_down && cfg.second_mux[6:5] != 2'b00) [*2] |-> reference_on)
    else $error("reference dropped against its field");
  filter_len_a: assert property (
    $fell(filter_reset) && !powered_down |-> int'(fr_cnt_r) >= FR_MIN)
    else $error("filter reset too short");
  ready_clean_a: assert property (
    $fell(data_out_ready_pin) |-> !filter_reset && !digital_reset)
    else $error("ready fell during a reset hold");
  pulse_down_a: assert property ($fell(data_out_ready_pin) &&
    !start_pin && !$past(start_pin, 4) |-> ##[0:3] powered_down)
    else $error("no shutdown after pulsed conversion");
  wake_start_a: assert property ($rose(start_pin) &&
    powered_down && !digital_reset |-> ##[2:6] (filter_reset && !powered_down))
    else $error("start rise did not wake with filter reset");
  cover property ($fell(data_out_ready_pin));
  cover property ($rose(powered_down));
  cover property ($fell(digital_reset) && reset_pin_n);
endmodule
bind adc_seq adc_seq_monitor #(.TIME_SHIFT(TIME_SHIFT), .MOD_DIV(MOD_DIV))
  i_adc_seq_monitor (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .start_pin(start_pin), .reset_pin_n(reset_pin_n),
  .data_out_ready_pin(data_out_ready_pin), .filter_reset(filter_reset),
  .powered_down(powered_down), .reference_on(reference_on),
  .digital_reset(digital_reset), .clk_sel_ext(clk_sel_ext), .cfg(cfg));

/* tb/adc_seq_host.sv */
// host model driving the serial port, start and reset pins
`timescale 1ns/1ps
module adc_seq_host (
  input  wire logic hclk,
  input  wire logic digital_reset,
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  output logic      start_pin,
  output logic      reset_pin_n
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    start_pin = 1'b0;
    reset_pin_n = 1'b1;
  end
  // ********
  // serial frames, sclk stands low outside them
  // ********
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    while (digital_reset !== 1'b0 && n < 5000) begin
      @(posedge hclk);
      n++;
    end
    if (digital_reset !== 1'b0) begin
      adc_seq_tb.n_fail++;
      adc_seq_tb.wrap_up();
    end
    cs_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      @(posedge hclk);
      sclk <= 1'b0;
      din  <= b[i];
      repeat (8) @(posedge hclk);
      sclk <= 1'b1; // 160 ns period, bytes back to back
      repeat (7) @(posedge hclk);
    end
  endtask
  task automatic close(input int gap);
    @(posedge hclk);
    sclk <= 1'b0;
    din  <= ~din; // released line keeps no stale bit
    cs_n <= 1'b1;
    repeat (gap) @(posedge hclk);
  endtask
  task automatic cmd(input logic [7:0] c);
    put(c);
    close(4);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    put({4'h4, a});
    put(8'h00);
    put(v);
    close(1600); // over 64 osc clocks before another write
  endtask
  task automatic set_start(input logic v);
    @(posedge hclk);
    start_pin <= v;
  endtask
  task automatic set_reset(input logic v);
    @(posedge hclk);
    reset_pin_n <= v;
  endtask
endmodule

/* tb/adc_seq_tb.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
`define WAIT(c, lim) begin k = 0; while (!(c) && k < (lim)) begin \
  @(posedge hclk); k++; end if (!(c)) begin n_fail++; wrap_up(); \
  end end
module adc_seq_tb;
  import adc_seq_pkg::*;
  localparam int TS = 8;
  localparam int RT = 9;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic        start_pin, reset_pin_n, sclk, cs_n, din, filter_reset;
  logic        data_out_ready_pin, powered_down, reference_on;
  logic        digital_reset, clk_sel_ext;
  cfg_t        cfg;
  int          n_fail, compares, k;
  adc_seq #(.TIME_SHIFT(TS), .MOD_DIV(16)) i_adc_seq (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .start_pin,
    .reset_pin_n, .sclk, .cs_n, .din, .data_out_ready_pin, .filter_reset,
    .powered_down, .reference_on, .digital_reset, .clk_sel_ext, .cfg);
  adc_seq_host i_adc_seq_host (.hclk, .digital_reset, .sclk, .cs_n, .din,
    .start_pin, .reset_pin_n);
  always #5 hclk = ~hclk;
  // ********
  // bus cycles and helpers
  // ********
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    `WAIT(hreadyout === 1'b1, 50)
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    `WAIT(hreadyout === 1'b1, 50)
    rd = hrdata;
  endtask
  // phase accumulator jitter allows one osc tick either way
  task automatic near(input int got, input int t);
    `CHK(got >= (t - 1) * 24 && got <= (t + 1) * 25 + 4, 1'b1)
  endtask
  task automatic wrap_up();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_por();
    `CHK(digital_reset, 1'b1)
    `WAIT(digital_reset === 1'b0, 20000)
    near(k, POR_OSC_CYCLES >> TS);
    ahb(1'b0, OFS_CFG, '0);
    `CHK(rd, 32'h0000_0001)
    ahb(1'b0, OFS_CTRL, '0);
    `CHK(rd[0], 1'b0)
    ahb(1'b1, 8'h14, 32'hffff_ffff);
    ahb(1'b0, 8'h10, '0);
    `CHK(rd, 32'h0)
    ahb(1'b1, OFS_CTRL, 32'h1);
    ahb(1'b0, OFS_CTRL, '0);
    `CHK(rd[0], 1'b1)
    $display("t_por done");
  endtask
  task automatic t_cfg();
    i_adc_seq_host.set_start(1'b1);
    i_adc_seq_host.put({CMD_WREG, IDX_RATE_GAIN});
    i_adc_seq_host.put(8'h00);
    i_adc_seq_host.put(8'h09);
    `CHK(cfg.rate_gain, 8'h09)
    `CHK(filter_reset, 1'b1)
    i_adc_seq_host.close(1600);
    i_adc_seq_host.put({CMD_WREG, IDX_INPUT_MUX});
    i_adc_seq_host.put(8'h01);
    i_adc_seq_host.put(8'h23);
    `CHK(cfg.input_mux, 8'h23)
    `CHK(cfg.bias, 8'h00)
    i_adc_seq_host.put(8'h05);
    `CHK(cfg.bias, 8'h05)
    i_adc_seq_host.close(1600);
    i_adc_seq_host.cmd(CMD_SYNC);
    `CHK(filter_reset, 1'b1)
    $display("t_cfg done");
  endtask
  task automatic t_single();
    i_adc_seq_host.set_start(1'b0);
    `WAIT(powered_down === 1'b1, 600)
    `CHK(data_out_ready_pin, 1'b0)
    i_adc_seq_host.cmd(CMD_RDATA);
    `CHK(data_out_ready_pin, 1'b1)
    repeat (300) @(posedge hclk);
    `CHK(powered_down, 1'b1)
    i_adc_seq_host.set_start(1'b1);
    repeat (3) @(posedge hclk);
    i_adc_seq_host.set_start(1'b0);
    `WAIT(data_out_ready_pin === 1'b0, 2000)
    near(k + 5, FIRST_LAT[RT] >> TS);
    `WAIT(powered_down === 1'b1, 10)
    $display("t_single done");
  endtask
  task automatic t_cont();
    i_adc_seq_host.set_start(1'b1);
    repeat (8) @(posedge hclk);
    `CHK(powered_down, 1'b0)
    `CHK(filter_reset, 1'b1)
    repeat (3) begin
      `WAIT(data_out_ready_pin === 1'b0, 2000)
      `CHK(powered_down, 1'b0)
      i_adc_seq_host.cmd(CMD_RDATA);
      `CHK(data_out_ready_pin, 1'b1)
    end
    $display("t_cont done");
  endtask
  task automatic t_sleep();
    i_adc_seq_host.wr(IDX_SECOND_MUX, 8'h20);
    i_adc_seq_host.cmd(CMD_SLEEP);
    `CHK(powered_down, 1'b1)
    `CHK(reference_on, 1'b1)
    i_adc_seq_host.cmd(CMD_WAKEUP);
    `CHK(powered_down, 1'b0)
    `CHK(filter_reset, 1'b1)
    i_adc_seq_host.wr(IDX_SECOND_MUX, 8'h00);
    i_adc_seq_host.cmd(CMD_SLEEP);
    `CHK(reference_on, 1'b0)
    i_adc_seq_host.cmd(CMD_WAKEUP);
    ahb(1'b1, OFS_CMD, {24'h0, CMD_SLEEP});
    ahb(1'b0, OFS_STATUS, '0);
    `CHK(rd[5:0], {3'b100, ST_PDOWN})
    ahb(1'b1, OFS_CMD, {24'h0, CMD_WAKEUP});
    ahb(1'b0, OFS_STATUS, '0);
    `CHK(rd[5:0], {3'b000, ST_FRST})
    $display("t_sleep done");
  endtask
  task automatic t_cal();
    i_adc_seq_host.cmd(CMD_CAL);
    i_adc_seq_host.set_start(1'b0);
    `WAIT(powered_down === 1'b1, 5000)
    near(k + 6, (50 + 32 * 16 + 16 * NEXT_LAT[RT]) >> TS);
    `CHK(data_out_ready_pin, 1'b0)
    $display("t_cal done");
  endtask
  task automatic t_pin();
    i_adc_seq_host.set_reset(1'b0);
    repeat (6) @(posedge hclk);
    `CHK(digital_reset, 1'b1)
    `CHK(cfg, 32'h0000_0001)
    `CHK(clk_sel_ext, 1'b0)
    i_adc_seq_host.set_reset(1'b1);
    `WAIT(digital_reset === 1'b0, 2000)
    near(k, RST_HOLD_OSC >> TS);
    i_adc_seq_host.wr(IDX_INPUT_MUX, 8'h45);
    `CHK(cfg, 32'h0000_0045)
    $display("t_pin done");
  endtask
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = '0;
    hwrite = 1'b0;
    hwdata = '0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_por();
    t_cfg();
    t_single();
    t_cont();
    t_sleep();
    t_cal();
    t_pin();
    wrap_up();
  end
endmodule
